// file: scms_pkg.sv
package scms_pkg;
    // ************************************************************
    // Control method codes
    // ************************************************************
    localparam logic [3:0] METHOD_TORQUE     = 4'h2;
    localparam logic [3:0] METHOD_CONTACT_LO = 4'h3;
    localparam logic [3:0] METHOD_CONTACT_HI = 4'h6;
    localparam logic [3:0] METHOD_SOFT_START = 4'h5;
    localparam logic [3:0] METHOD_TRQ_SPD    = 4'h9;
    localparam logic [1:0] OPT_NONE          = 2'h0;
    localparam logic [1:0] OPT_TLIM          = 2'h1;
    localparam logic [1:0] OPT_TFF           = 2'h2;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] ADDR_CONFIG   = 4'h0;
    localparam logic [3:0] ADDR_SPEEDCAP = 4'h1;
    localparam logic [3:0] ADDR_ALLOC    = 4'h2;
    localparam logic [3:0] ADDR_STATUS   = 4'h3;
    localparam logic [3:0] ADDR_SPEEDREF = 4'h4;
    localparam int CFG_METHOD_LSB = 0;
    localparam int CFG_OPT_LSB    = 4;
    localparam int CFG_LIMSEL_BIT = 6;
    localparam logic [31:0] CONFIG_RESET   = 32'h00000000;
    localparam logic [15:0] SPEEDCAP_RESET = 16'h2710;
    localparam logic [2:0]  ALLOC_RESET    = 3'h0;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ        = 125;
    localparam int SAMPLE_US      = 2000;
    localparam int SAMPLE_CYC_MAX = SAMPLE_US * CLK_MHZ;
    localparam int DEBOUNCE_US    = 1000;
    localparam int DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
    localparam int RAMP_STEP_US   = 100;
    localparam int RAMP_STEP_CYC  = RAMP_STEP_US * CLK_MHZ;
    // ************************************************************
    // Active sub-mode
    // ************************************************************
    typedef enum logic [2:0] {
        SCMS_MODE_SPEED   = 3'b000,
        SCMS_MODE_TORQUE  = 3'b001,
        SCMS_MODE_CONTACT = 3'b010,
        SCMS_MODE_PULSE   = 3'b011
    } scms_mode_t;
endpackage

// file: scms_debounce.sv
`timescale 1ns/10ps
module scms_debounce #(
    parameter int WIDTH   = 4,
    parameter int HOLD_CY = 125000
) (
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] raw_n,
    output logic      [WIDTH-1:0] clean_on
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic        sync1_reg;
            logic        sync2_reg;
            logic [17:0] cnt_reg;
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    sync1_reg <= 1'b1;
                    sync2_reg <= 1'b1;
                end else begin
                    sync1_reg <= raw_n[g];
                    sync2_reg <= sync1_reg;
                end
            end
            // Low level means contact on; change accepted after a stable hold
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    cnt_reg     <= 18'h0;
                    clean_on[g] <= 1'b0;
                end else if (sync2_reg == clean_on[g]) begin
                    if (cnt_reg >= 18'(HOLD_CY - 1)) begin
                        clean_on[g] <= ~sync2_reg;
                        cnt_reg     <= 18'h0;
                    end else begin
                        cnt_reg <= cnt_reg + 18'h1;
                    end
                end else begin
                    cnt_reg <= 18'h0;
                end
            end
        end
    endgenerate
endmodule // scms_debounce

// file: scms_ramp.sv
`timescale 1ns/10ps
module scms_ramp #(
    parameter int STEP_CY = 12500
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        enable,
    input  wire logic [15:0] target,
    input  wire logic [15:0] accel_step,
    output logic      [15:0] speed_out
);
    logic [15:0] tick_reg;
    logic        tick;
    assign tick = (tick_reg >= 16'(STEP_CY - 1));
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_reg <= 16'h0;
        end else begin
            tick_reg <= tick ? 16'h0 : tick_reg + 16'h1;
        end
    end
    // Without ramp the output follows the target at once
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            speed_out <= 16'h0;
        end else if (!enable || accel_step == 16'h0) begin
            speed_out <= target;
        end else if (tick) begin
            if (target > speed_out) begin
                speed_out <= (target - speed_out > accel_step) ? speed_out + accel_step : target;
            end else if (target < speed_out) begin
                speed_out <= (speed_out - target > accel_step) ? speed_out - accel_step : target;
            end
        end
    end
endmodule // scms_ramp

// file: scms_mode_selector.sv
// Operation
// - Soft start ramps only in contact speed control with method 5.
// - Pulse reference motion never ramps.
// - After contact-to-pulse switch while running, pulses wait for positioning done.
// - Speed select contact changes take effect within 2 ms.
// - Method 2 runs pure torque control from the torque reference.
// - Pure torque with limit select 1 ignores speed reference as command.
// - Torque control caps speed at the torque mode speed cap.
// - Method 9 switches torque and speed by control select contact.
// - Method 9: contact off means torque, on means speed.
// - Method 9 torque, limit select 1: speed reference limits both directions.
// - Method 9 uses torque reference as command, feed-forward or limit.
// - Speed option 0 unused, 1 torque limit, 2 feed-forward.
// - Control select works only when allocated to an input.
// - One external torque limit level, taken from the torque reference, is supported.
// - Contacts are active low.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/10ps
module scms_mode_selector #(
    parameter int DEBOUNCE_CY = scms_pkg::DEBOUNCE_CYC,
    parameter int STEP_CY     = scms_pkg::RAMP_STEP_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        proportional_ctrl_in_n,
    input  wire logic        speed_select_a_n,
    input  wire logic        speed_select_b_n,
    input  wire logic        ext_limit_in_n,
    input  wire logic        motor_running,
    input  wire logic        in_position,
    input  wire logic        pulse_in,
    input  wire logic        max_limit_hit,
    input  wire logic [15:0] speed_ref,
    input  wire logic [15:0] torque_ref,
    output logic             positioning_done_out,
    output logic             pulse_accept,
    output logic [15:0]      speed_cmd,
    output logic [15:0]      torque_cmd,
    output logic [15:0]      torque_ff,
    output logic [15:0]      torque_limit,
    output logic [15:0]      speed_limit,
    output logic             speed_limit_bidir,
    output logic             reverse_dir,
    output logic [2:0]       mode_out
);
    default clocking dflt_cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // ************************************************************
    // Registers
    // ************************************************************
    logic [31:0] config_reg;
    logic [15:0] speedcap_reg;
    logic [2:0]  alloc_reg;
    logic [15:0] speed1_reg;
    logic [3:0]  method;
    logic [1:0]  opt;
    logic        limsel;
    assign method = config_reg[scms_pkg::CFG_METHOD_LSB +: 4];
    assign opt    = config_reg[scms_pkg::CFG_OPT_LSB +: 2];
    assign limsel = config_reg[scms_pkg::CFG_LIMSEL_BIT];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            config_reg   <= scms_pkg::CONFIG_RESET;
            speedcap_reg <= scms_pkg::SPEEDCAP_RESET;
            alloc_reg    <= scms_pkg::ALLOC_RESET;
            speed1_reg   <= 16'h0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                scms_pkg::ADDR_CONFIG:   config_reg   <= reg_wdata;
                scms_pkg::ADDR_SPEEDCAP: speedcap_reg <= reg_wdata[15:0];
                scms_pkg::ADDR_ALLOC:    alloc_reg    <= reg_wdata[2:0];
                scms_pkg::ADDR_SPEEDREF: speed1_reg   <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Contact conditioning
    // ************************************************************
    logic [3:0] on;
    scms_debounce #(.WIDTH(4), .HOLD_CY(DEBOUNCE_CY)) u_deb (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .raw_n    ({ext_limit_in_n, speed_select_b_n, speed_select_a_n, proportional_ctrl_in_n}),
        .clean_on (on)
    );
    logic sel_on;
    assign sel_on = on[0] & alloc_reg[0];

    // ************************************************************
    // Mode decision
    // ************************************************************
    logic contact_mode;
    logic speeds_zero;
    scms_pkg::scms_mode_t mode;
    assign contact_mode = (method >= scms_pkg::METHOD_CONTACT_LO) && (method <= scms_pkg::METHOD_CONTACT_HI);
    assign speeds_zero  = !on[1] && !on[2];
    always_comb begin
        if (method == scms_pkg::METHOD_TORQUE) begin
            mode = scms_pkg::SCMS_MODE_TORQUE;
        end else if (method == scms_pkg::METHOD_TRQ_SPD) begin
            mode = sel_on ? scms_pkg::SCMS_MODE_SPEED : scms_pkg::SCMS_MODE_TORQUE;
        end else if (contact_mode && speeds_zero && method == scms_pkg::METHOD_SOFT_START) begin
            mode = scms_pkg::SCMS_MODE_PULSE;
        end else if (contact_mode) begin
            mode = scms_pkg::SCMS_MODE_CONTACT;
        end else begin
            mode = scms_pkg::SCMS_MODE_SPEED;
        end
    end
    assign mode_out = mode;

    // ************************************************************
    // Pulse gating after preset speed run
    // ************************************************************
    logic prev_contact_reg;
    logic pulse_block_reg;
    logic block_set;
    assign block_set = prev_contact_reg && mode == scms_pkg::SCMS_MODE_PULSE && motor_running;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_contact_reg <= 1'b0;
        end else begin
            prev_contact_reg <= (mode == scms_pkg::SCMS_MODE_CONTACT);
        end
    end
    // Set beats the release so a fresh switch is never lost
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse_block_reg <= 1'b0;
        end else if (block_set) begin
            pulse_block_reg <= 1'b1;
        end else if (positioning_done_out || mode != scms_pkg::SCMS_MODE_PULSE) begin
            pulse_block_reg <= 1'b0;
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            positioning_done_out <= 1'b0;
        end else begin
            positioning_done_out <= in_position && !block_set;
        end
    end
    assign pulse_accept = pulse_in && mode == scms_pkg::SCMS_MODE_PULSE && !pulse_block_reg && !block_set;

    // ************************************************************
    // Reference routing
    // ************************************************************
    logic [15:0] ramp_speed;
    logic [15:0] contact_target;
    always_comb begin
        unique case ({on[2], on[1]})
            2'b01:   contact_target = speed1_reg;
            2'b11:   contact_target = speed1_reg << 1;
            2'b10:   contact_target = speed1_reg + (speed1_reg << 1);
            default: contact_target = (method == 4'h4) ? speed_ref : 16'h0;
        endcase
    end
    scms_ramp #(.STEP_CY(STEP_CY)) u_ramp (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .enable     (method == scms_pkg::METHOD_SOFT_START && mode == scms_pkg::SCMS_MODE_CONTACT),
        .target     (contact_target),
        .accel_step (config_reg[31:16]),
        .speed_out  (ramp_speed)
    );

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            speed_cmd         <= 16'h0;
            torque_cmd        <= 16'h0;
            torque_ff         <= 16'h0;
            torque_limit      <= 16'hffff;
            speed_limit       <= scms_pkg::SPEEDCAP_RESET;
            speed_limit_bidir <= 1'b0;
            reverse_dir       <= 1'b0;
        end else begin
            speed_cmd         <= 16'h0;
            torque_cmd        <= 16'h0;
            torque_ff         <= 16'h0;
            torque_limit      <= on[3] ? torque_ref : 16'hffff;
            speed_limit       <= speedcap_reg;
            speed_limit_bidir <= 1'b0;
            reverse_dir       <= contact_mode & on[0];
            unique case (mode)
                scms_pkg::SCMS_MODE_TORQUE: begin
                    torque_cmd <= torque_ref;
                    if (limsel) begin
                        speed_limit       <= (speed_ref < speedcap_reg) ? speed_ref : speedcap_reg;
                        speed_limit_bidir <= 1'b1;
                    end
                end
                scms_pkg::SCMS_MODE_SPEED: begin
                    speed_cmd <= speed_ref;
                    if (method == scms_pkg::METHOD_TRQ_SPD) begin
                        if (opt == scms_pkg::OPT_TLIM) begin
                            torque_limit <= torque_ref;
                        end else if (opt == scms_pkg::OPT_TFF) begin
                            torque_ff <= torque_ref;
                        end
                    end
                end
                scms_pkg::SCMS_MODE_CONTACT: speed_cmd <= ramp_speed;
                scms_pkg::SCMS_MODE_PULSE:   speed_cmd <= 16'h0;
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                scms_pkg::ADDR_CONFIG:   reg_rdata <= config_reg;
                scms_pkg::ADDR_SPEEDCAP: reg_rdata <= {16'h0, speedcap_reg};
                scms_pkg::ADDR_ALLOC:    reg_rdata <= {29'h0, alloc_reg};
                scms_pkg::ADDR_STATUS:   reg_rdata <= {23'h0, pulse_block_reg, positioning_done_out, mode, on};
                scms_pkg::ADDR_SPEEDREF: reg_rdata <= {16'h0, speed1_reg};
                default:                 reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // Lag counter stands in for a two-millisecond repetition, far too deep to unroll
    logic [17:0] lag_cnt_reg;
    logic        lagging;
    assign lagging = (speed_select_a_n == on[1]) || (speed_select_b_n == on[2]);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lag_cnt_reg <= 18'h0;
        end else if (!lagging) begin
            lag_cnt_reg <= 18'h0;
        end else if (lag_cnt_reg < 18'(scms_pkg::SAMPLE_CYC_MAX)) begin
            lag_cnt_reg <= lag_cnt_reg + 18'h1;
        end
    end

    a_torque_method: assert property (method == scms_pkg::METHOD_TORQUE
        |-> mode == scms_pkg::SCMS_MODE_TORQUE) else $error("torque method wrong mode");

    a_sel_speed: assert property ((method == scms_pkg::METHOD_TRQ_SPD && sel_on)
        |-> mode == scms_pkg::SCMS_MODE_SPEED) else $error("sel on not speed");

    a_sel_off_torque: assert property ((method == scms_pkg::METHOD_TRQ_SPD && !sel_on)
        |-> mode == scms_pkg::SCMS_MODE_TORQUE) else $error("sel off not torque");

    a_sel_unalloc: assert property ((method == scms_pkg::METHOD_TRQ_SPD && !alloc_reg[0])
        |-> mode == scms_pkg::SCMS_MODE_TORQUE) else $error("unallocated select acted");

    a_pulse_block: assert property (block_set
        |=> pulse_block_reg && !positioning_done_out && !pulse_accept) else $error("pulse block not raised");

    a_ff_route: assert property (
        (mode == scms_pkg::SCMS_MODE_SPEED && method == scms_pkg::METHOD_TRQ_SPD && opt == scms_pkg::OPT_TFF)
        |=> torque_ff == $past(torque_ref)) else $error("feed-forward not routed");

    a_opt_none: assert property ((mode == scms_pkg::SCMS_MODE_SPEED && opt == scms_pkg::OPT_NONE)
        |=> torque_ff == 16'h0 && torque_cmd == 16'h0) else $error("torque input used");

    a_torque_cmd: assert property (mode == scms_pkg::SCMS_MODE_TORQUE
        |=> torque_cmd == $past(torque_ref) && speed_cmd == 16'h0) else $error("torque cmd wrong");

    a_cap_limit: assert property (mode == scms_pkg::SCMS_MODE_TORQUE
        |=> speed_limit <= $past(speedcap_reg)) else $error("speed cap exceeded");

    a_limit_bidir: assert property ((mode == scms_pkg::SCMS_MODE_TORQUE && limsel)
        |=> speed_limit_bidir) else $error("limit not both ways");

    a_ext_limit: assert property (on[3]
        |=> torque_limit == $past(torque_ref)) else $error("external limit ignored");

    a_pulse_noramp: assert property (mode == scms_pkg::SCMS_MODE_PULSE
        |=> speed_cmd == 16'h0) else $error("pulse mode drove speed");

    a_soft_only: assert property (
        (mode == scms_pkg::SCMS_MODE_CONTACT && method != scms_pkg::METHOD_SOFT_START) [*2]
        |=> speed_cmd == $past(contact_target, 2)) else $error("ramp outside soft start method");

    a_contact_dir: assert property (contact_mode
        |=> reverse_dir == $past(on[0])) else $error("direction contact ignored");

    a_select_lag: assert property (lag_cnt_reg < 18'(scms_pkg::SAMPLE_CYC_MAX)) else $error("select too slow");

    // Covers for the main scenarios
    c_block: cover property (block_set ##[1:50] positioning_done_out);
    c_switch: cover property ($rose(sel_on));
    c_ramp: cover property (mode == scms_pkg::SCMS_MODE_CONTACT ##1 $changed(ramp_speed));
    c_pulse_ok: cover property (pulse_accept);
    c_speed3: cover property (contact_mode && on[2] && !on[1]);
endmodule // scms_mode_selector

// file: scms_host_model.sv
`timescale 1ns/10ps
// ************************************************************
// Host controller pulse source
// ************************************************************
module scms_host_model #(
    parameter int T1_CY = 250001,
    parameter int BURST = 8
) (
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic positioning_done_out,
    input  wire logic send_en,
    input  wire logic early,
    output logic      pulse_in
);
    int unsigned gap_cnt;
    int unsigned burst_cnt;
    logic        done_seen;

    // Early only when a scenario asks for pulses before positioning done
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse_in  <= 1'b0;
            gap_cnt   <= 0;
            burst_cnt <= 0;
            done_seen <= 1'b0;
        end else if (!send_en) begin
            pulse_in  <= 1'b0;
            gap_cnt   <= 0;
            burst_cnt <= 0;
            done_seen <= 1'b0;
        end else if (early) begin
            pulse_in <= 1'b1;
        end else if (!done_seen) begin
            pulse_in  <= 1'b0;
            done_seen <= positioning_done_out;
        end else if (gap_cnt < T1_CY) begin
            pulse_in <= 1'b0;
            gap_cnt  <= gap_cnt + 1;
        end else begin
            pulse_in  <= (burst_cnt < BURST);
            burst_cnt <= burst_cnt + 1;
        end
    end
endmodule // scms_host_model

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
    localparam logic [15:0] SPD1 = 16'h0100;
    logic        core_clk, arst_n, reg_wr, reg_rd, rd_d, probe_v;
    logic [3:0]  reg_addr, probe_sel;
    logic [31:0] reg_wdata, reg_rdata, view, exp_v;
    logic        prop_n, sel_a_n, sel_b_n, ext_n, motor_running, in_position, pulse_in, send_en, early;
    logic [15:0] speed_ref, torque_ref, speed_cmd, torque_cmd, torque_ff, torque_limit, speed_limit;
    logic        positioning_done_out, pulse_accept, speed_limit_bidir, rev_dir;
    logic [2:0]  mode_out;
    logic [31:0] q[$];
    int          err_total, checks_done, i;
    integer      seed;

    scms_mode_selector #(.DEBOUNCE_CY(4), .STEP_CY(4)) uut (
        .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .proportional_ctrl_in_n(prop_n), .speed_select_a_n(sel_a_n), .speed_select_b_n(sel_b_n),
        .ext_limit_in_n(ext_n), .motor_running(motor_running), .in_position(in_position),
        .pulse_in(pulse_in), .max_limit_hit(1'b0), .speed_ref(speed_ref), .torque_ref(torque_ref),
        .positioning_done_out(positioning_done_out), .pulse_accept(pulse_accept),
        .speed_cmd(speed_cmd), .torque_cmd(torque_cmd), .torque_ff(torque_ff),
        .torque_limit(torque_limit), .speed_limit(speed_limit),
        .speed_limit_bidir(speed_limit_bidir), .reverse_dir(rev_dir), .mode_out(mode_out));

    scms_host_model #(.T1_CY(9), .BURST(8)) host (
        .core_clk(core_clk), .arst_n(arst_n), .positioning_done_out(positioning_done_out),
        .send_en(send_en), .early(early), .pulse_in(pulse_in));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always_comb begin
        case (probe_sel)
            4'h0: view = {29'h0, mode_out};
            4'h1: view = {16'h0, speed_cmd};
            4'h2: view = {16'h0, torque_cmd};
            4'h3: view = {16'h0, torque_ff};
            4'h4: view = {16'h0, torque_limit};
            4'h5: view = {16'h0, speed_limit};
            4'h6: view = {31'h0, speed_limit_bidir};
            4'h7: view = {31'h0, pulse_accept};
            4'h8: view = {31'h0, positioning_done_out};
            4'ha: view = {31'h0, rev_dir};
            default: view = {31'h0, speed_cmd < SPD1};
        endcase
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d errors=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        q.push_back(exp);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic probe(input logic [3:0] s, input logic [31:0] exp);
        @(posedge core_clk);
        probe_sel <= s;
        probe_v   <= 1'b1;
        q.push_back(exp);
        @(posedge core_clk);
        probe_v <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // ************************************************************
    // Result monitor
    // ************************************************************
    always @(posedge core_clk) rd_d <= reg_rd;
    always @(negedge core_clk) begin
        if (rd_d || probe_v) begin
            exp_v = q.pop_front();
            check(rd_d ? reg_rdata : view, exp_v);
        end
    end

    initial begin
        #200000;
        err_total++;
        results();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        seed = 32'hab076b3f;
        arst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0;
        probe_v = 1'b0; probe_sel = 4'h0; prop_n = 1'b1; sel_a_n = 1'b1;
        sel_b_n = 1'b1; ext_n = 1'b1;
        motor_running = 1'b0; in_position = 1'b0; send_en = 1'b0; early = 1'b0;
        err_total = 0; checks_done = 0;
        speed_ref = {1'b0, 15'($random(seed))};
        torque_ref = 16'($random(seed));
        idle(4);
        arst_n <= 1'b1;
        rd(scms_pkg::ADDR_CONFIG, 32'h0);
        rd(scms_pkg::ADDR_SPEEDCAP, 32'h00002710);
        rd(scms_pkg::ADDR_ALLOC, 32'h0);
        probe(4'h4, 32'h0000ffff);
        probe(4'h5, 32'h00002710);
        @(posedge core_clk) ext_n <= 1'b0;
        idle(8);
        probe(4'h4, {16'h0, torque_ref});
        @(posedge core_clk) ext_n <= 1'b1;
        wr(scms_pkg::ADDR_SPEEDCAP, 32'h00001234);
        wr(4'hf, 32'h5a5a5a5a);
        rd(scms_pkg::ADDR_SPEEDCAP, 32'h00001234);
        rd(4'hf, 32'h0);
        // Dedicated torque control
        wr(scms_pkg::ADDR_CONFIG, 32'h2);
        idle(3);
        probe(4'h0, 32'h1);
        probe(4'h2, {16'h0, torque_ref});
        probe(4'h5, 32'h00001234);
        wr(scms_pkg::ADDR_CONFIG, 32'h42);
        idle(3);
        probe(4'h1, 32'h0);
        // Torque and speed switching, select not allocated yet
        wr(scms_pkg::ADDR_CONFIG, 32'h9);
        @(posedge core_clk) prop_n <= 1'b0;
        idle(14);
        probe(4'h0, 32'h1);
        wr(scms_pkg::ADDR_ALLOC, 32'h1);
        idle(3);
        probe(4'h0, 32'h0);
        for (i = 0; i < 3; i++) begin
            wr(scms_pkg::ADDR_CONFIG, 32'h9 | (i << 4));
            idle(3);
            probe(4'h1, {16'h0, speed_ref});
            probe(4'h4, (i == 1) ? {16'h0, torque_ref} : 32'h0000ffff);
            probe(4'h3, (i == 2) ? {16'h0, torque_ref} : 32'h0);
        end
        @(posedge core_clk) prop_n <= 1'b1;
        wr(scms_pkg::ADDR_CONFIG, 32'h49);
        idle(14);
        probe(4'h0, 32'h1);
        probe(4'h2, {16'h0, torque_ref});
        probe(4'h5, {16'h0, ((speed_ref < 16'h1234) ? speed_ref : 16'h1234)});
        probe(4'h6, 32'h1);
        // Soft start in contact speed control
        wr(scms_pkg::ADDR_SPEEDREF, {16'h0, SPD1});
        wr(scms_pkg::ADDR_CONFIG, 32'h00100005);
        @(posedge core_clk) sel_a_n <= 1'b0;
        motor_running <= 1'b1;
        idle(12);
        probe(4'h0, 32'h2);
        probe(4'h9, 32'h1);
        idle(150);
        probe(4'h1, {16'h0, SPD1});
        @(posedge core_clk) sel_b_n <= 1'b0;
        prop_n <= 1'b0;
        idle(80);
        probe(4'h1, {15'h0, SPD1, 1'b0});
        probe(4'ha, 32'h1);
        @(posedge core_clk) sel_a_n <= 1'b1;
        idle(80);
        probe(4'h1, {16'h0, 16'(SPD1 * 3)});
        // Switch to pulse reference while running
        @(posedge core_clk) send_en <= 1'b1;
        early <= 1'b1;
        sel_b_n <= 1'b1;
        prop_n <= 1'b1;
        idle(12);
        probe(4'h0, 32'h3);
        for (i = 0; i < 3; i++) probe(4'h7, 32'h0);
        @(posedge core_clk) in_position <= 1'b1;
        for (i = 0; i < 20 && positioning_done_out !== 1'b1; i++) @(negedge core_clk);
        check(32'(i < 20), 32'h1);
        probe(4'h8, 32'h1);
        early <= 1'b0;
        idle(2);
        for (i = 0; i < 40 && pulse_in !== 1'b1; i++) @(negedge core_clk);
        check(32'(i < 40), 32'h1);
        probe(4'h7, 32'h1);
        idle(4);
        results();
    end
endmodule // tb_top
